// ---- src/cke_power_defs.svh ----
// Constants for the clock-enable power-state logic of the memory device.
// Assumes inclusion by bare name from every design file of this pair.
`ifndef CKE_POWER_DEFS_SVH
`define CKE_POWER_DEFS_SVH
// Clock period in picoseconds (50 MHz)
`define CLK_PERIOD_PS 20000
// Minimum clock-enable pulse, in clock cycles
`define MIN_CLOCK_ENABLE_PULSE 4
// Mode-register command interval, cycles
`define MODE_REG_CMD_INTERVAL 4
// Mode-register update interval, cycles
`define MODE_REG_UPDATE_INTERVAL 12
// Self-refresh exit interval, cycles
`define SELF_REFRESH_EXIT_INTERVAL 16
// Self-refresh exit interval for the delay-locked loop, cycles
`define SELF_REFRESH_EXIT_DLL_INTERVAL 512
// First write after self-refresh exit, cycles
`define FIRST_WRITE_AFTER_SR 512
// Power-down exit interval, cycles
`define POWER_DOWN_EXIT_INTERVAL 3
// Width of the timing counters
`define TIMER_W 10
// Number of banks
`define BANK_COUNT 8
`endif

// ---- src/cke_power_pkg.sv ----
// Types shared by both ends of the clock-enable link.
// Assumes nothing beyond a SystemVerilog compiler.
package cke_power_pkg;
  // Decoded command at a clock edge
  typedef enum logic [3:0] {
    CMD_DESELECT = 4'h0,
    CMD_NOP = 4'h1,
    CMD_REFRESH = 4'h2,
    CMD_MODE_SET = 4'h3,
    CMD_PRECHARGE = 4'h4,
    CMD_ACTIVATE = 4'h5,
    CMD_WRITE = 4'h6,
    CMD_READ = 4'h7,
    CMD_ZQ = 4'h8
  } cmd_t;
  // Device power state, one-hot
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_ACTIVE = 5'h02,
    ST_ACT_PD = 5'h04,
    ST_PRE_PD = 5'h08,
    ST_SELF_REF = 5'h10
  } pstate_t;
endpackage

// ---- src/cke_link_if.sv ----
// Command and clock-enable pins between controller and memory device.
// Assumes both ends share clk_sys_i as the device clock.
`timescale 1ns/1ps
interface cke_link_if;
  logic cke; // Clock enable
  logic cs_n; // Chip select, active low
  logic ras_n; // Row strobe, active low
  logic cas_n; // Column strobe, active low
  logic we_n; // Write enable, active low
  logic a10; // Auto-precharge / all-banks bit
  logic [2:0] bank; // Bank address
  logic on_die_termination; // On-die termination request
  modport ctrl (output cke, cs_n, ras_n, cas_n, we_n, a10, bank, on_die_termination);
  modport dev (input cke, cs_n, ras_n, cas_n, we_n, a10, bank, on_die_termination);
endinterface

// ---- src/cke_power_device.sv ----
// Memory-device end: clock-enable power-state tracking.
// Assumes the controller keeps its own timing obligations on the link.
//
// Summary of operation
// - Sample enable and strobes on rising edge
// - Judge transition from previous and current enable
// - Enable low only after mode intervals
// - Unlisted combinations are illegal; flagged
// - Hold enable level for minimum pulse
// - Enable low twice keeps self refresh
// - Falling enable with bank open: active power-down
// - Fall during access: power-down by bank state
// - Only deselect/no-op at power-down edges
// - No refresh while in power down
// - Self refresh only from idle via refresh
// - No self-refresh entry during read/write
// - Idle needs closed banks, no burst, timings
// - Only deselect/no-op at self-refresh exit
// - Exit interval no-ops; reads after dll interval
// - First write 512 cycles after self refresh
// - Ignore commands in self refresh, power down
// - Termination off in self refresh; no influence
`timescale 1ns/1ps
`include "cke_power_defs.svh"
module cke_power_device (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  // Link from the controller
  cke_link_if.dev link,
  // Status to the user side
  output cke_power_pkg::pstate_t state_o,
  output logic refresh_busy_o,
  output logic odt_active_o,
  output logic illegal_o,
  output logic exit_busy_o
);
  import cke_power_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Sampled pins
  logic cke_prev; // Enable at the previous edge
  logic [`BANK_COUNT-1:0] bank_open; // Open-row map
  logic [`TIMER_W-1:0] burst_cnt; // Remaining data-burst cycles
  logic [`TIMER_W-1:0] exit_cnt; // Exit-parameter countdown
  pstate_t state; // State just before this edge
  cmd_t cmd; // Command decoded at this edge
  logic quiet; // Deselect or no-op presented

  // Command from sampled strobe levels
  always_comb begin
    if (link.cs_n) begin
      cmd = CMD_DESELECT;
    end else begin
      case ({link.ras_n, link.cas_n, link.we_n})
        3'h7: cmd = CMD_NOP;
        3'h1: cmd = CMD_REFRESH;
        3'h0: cmd = CMD_MODE_SET;
        3'h2: cmd = CMD_PRECHARGE;
        3'h3: cmd = CMD_ACTIVATE;
        3'h4: cmd = CMD_WRITE;
        3'h5: cmd = CMD_READ;
        default: cmd = CMD_ZQ;
      endcase
    end
  end
  assign quiet = (cmd == CMD_DESELECT) || (cmd == CMD_NOP);

  ////////////////////////////////////////////////////////////////////////
  // Enable history
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cke_prev <= 1'b0;
    end else begin
      cke_prev <= link.cke;
    end
  end

  // Open-bank map; frozen while powered down since commands are ignored
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      bank_open <= '0;
    end else if (cke_prev && link.cke) begin
      if (cmd == CMD_ACTIVATE) begin
        bank_open[link.bank] <= 1'b1;
      end else if (cmd == CMD_PRECHARGE && link.a10) begin
        bank_open <= '0;
      end else if (cmd == CMD_PRECHARGE) begin
        bank_open[link.bank] <= 1'b0;
      end else if ((cmd == CMD_READ || cmd == CMD_WRITE) && link.a10) begin
        bank_open[link.bank] <= 1'b0; // Auto precharge
      end
    end
  end

  // Data-burst tracking, kept short: four clocks per burst
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      burst_cnt <= '0;
    end else if (cke_prev && link.cke &&
                 (cmd == CMD_READ || cmd == CMD_WRITE)) begin
      burst_cnt <= `TIMER_W'h004;
    end else if (burst_cnt != '0) begin
      burst_cnt <= burst_cnt - `TIMER_W'h001;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Power-state machine
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state <= ST_IDLE;
      illegal_o <= 1'b0;
    end else begin
      illegal_o <= 1'b0;
      case (state)
        ST_IDLE, ST_ACTIVE: begin
          if (cke_prev && !link.cke) begin
            if (cmd == CMD_REFRESH && state == ST_IDLE &&
                burst_cnt == '0) begin
              state <= ST_SELF_REF;
            end else if (!quiet) begin
              illegal_o <= 1'b1;
            end else if (bank_open != '0) begin
              state <= ST_ACT_PD;
            end else begin
              state <= ST_PRE_PD;
            end
          end else if (cke_prev && link.cke) begin
            if (bank_open == '0 && burst_cnt == '0 && exit_cnt == '0) begin
              state <= ST_IDLE;
            end else begin
              state <= ST_ACTIVE;
            end
          end
        end
        ST_ACT_PD, ST_PRE_PD: begin
          if (link.cke) begin
            if (!quiet) begin
              illegal_o <= 1'b1;
            end
            // Not idle yet: the exit countdown starts on this edge
            state <= ST_ACTIVE;
          end // no refresh, commands ignored meanwhile
        end
        ST_SELF_REF: begin
          if (link.cke) begin // low stays in self refresh
            if (!quiet) begin
              illegal_o <= 1'b1;
            end
            // Idle only once the self-refresh exit interval has run out
            state <= ST_ACTIVE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Exit-parameter countdown; idle waits for it to run out
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      exit_cnt <= '0;
    end else if (state == ST_SELF_REF && link.cke) begin
      exit_cnt <= `TIMER_W'(`SELF_REFRESH_EXIT_INTERVAL);
    end else if ((state == ST_ACT_PD || state == ST_PRE_PD) && link.cke) begin
      exit_cnt <= `TIMER_W'(`POWER_DOWN_EXIT_INTERVAL);
    end else if (exit_cnt != '0) begin
      exit_cnt <= exit_cnt - `TIMER_W'h001;
    end
  end

  // Status outputs, all registered
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      refresh_busy_o <= 1'b0;
      odt_active_o <= 1'b0;
      exit_busy_o <= 1'b0;
    end else begin
      // Internal refresh only runs in self refresh
      refresh_busy_o <= (state == ST_SELF_REF);
      // Termination never affects the state above
      odt_active_o <= link.on_die_termination && (state != ST_SELF_REF);
      exit_busy_o <= (exit_cnt != '0);
    end
  end
  assign state_o = state;
endmodule

// ---- src/cke_power_ctrl.sv ----
// Controller end: drives enable and commands, keeps link timing.
// Assumes the user holds a request until it is accepted.
`timescale 1ns/1ps
`include "cke_power_defs.svh"
module cke_power_ctrl (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  // Link to the device
  cke_link_if.ctrl link,
  // User requests
  input wire cke_power_pkg::cmd_t cmd_i,
  input wire logic [2:0] bank_i,
  input wire logic a10_i,
  input wire logic odt_i,
  input wire logic pd_req_i,
  input wire logic sr_req_i,
  input wire logic wake_req_i,
  // Status
  output logic accept_o,
  output logic asleep_o
);
  import cke_power_pkg::*;

  logic [`TIMER_W-1:0] pulse_cnt; // Enable pulse hold
  logic [`TIMER_W-1:0] mode_cnt; // Mode-register guard
  logic [`TIMER_W-1:0] srx_cnt; // Self-refresh exit guard
  logic [`TIMER_W-1:0] wr_cnt; // First-write guard
  logic [`TIMER_W-1:0] burst_cnt; // Burst in progress
  logic in_sr; // Device held in self refresh
  logic go_low; // Enable falls this cycle
  logic go_high; // Enable rises this cycle
  logic send; // User command is sent
  logic cmd_ok; // Command allowed by guards

  assign go_low = link.cke && (pd_req_i || sr_req_i) && pulse_cnt == '0 &&
                  mode_cnt == '0 && !(sr_req_i && burst_cnt != '0);
  assign go_high = !link.cke && wake_req_i && pulse_cnt == '0;
  always_comb begin
    cmd_ok = 1'b1;
    if (srx_cnt != '0) begin
      cmd_ok = 1'b0;
    end else if (cmd_i == CMD_WRITE && wr_cnt != '0) begin
      cmd_ok = 1'b0;
    end
  end
  assign send = link.cke && !go_low && cmd_ok &&
                cmd_i != CMD_DESELECT && cmd_i != CMD_NOP;

  ////////////////////////////////////////////////////////////////////////
  // Pins: quiet command on every enable edge except self-refresh entry, which carries refresh
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      link.cke <= 1'b1;
      {link.cs_n, link.ras_n, link.cas_n, link.we_n} <= 4'hF;
      link.a10 <= 1'b0;
      link.bank <= 3'h0;
      link.on_die_termination <= 1'b0;
      accept_o <= 1'b0;
    end else begin
      accept_o <= send;
      link.on_die_termination <= odt_i && !in_sr;
      link.a10 <= a10_i;
      link.bank <= bank_i;
      if (go_low) begin
        link.cke <= 1'b0;
        // Self-refresh entry carries refresh, power-down a deselect
        {link.cs_n, link.ras_n, link.cas_n, link.we_n} <=
          sr_req_i ? 4'h1 : 4'hF;
      end else if (go_high) begin
        link.cke <= 1'b1;
        {link.cs_n, link.ras_n, link.cas_n, link.we_n} <= 4'hF;
      end else if (send) begin
        case (cmd_i)
          CMD_REFRESH: {link.cs_n, link.ras_n, link.cas_n, link.we_n} <= 4'h1;
          CMD_MODE_SET: {link.cs_n, link.ras_n, link.cas_n, link.we_n} <= 4'h0;
          CMD_PRECHARGE: {link.cs_n, link.ras_n, link.cas_n, link.we_n} <= 4'h2;
          CMD_ACTIVATE: {link.cs_n, link.ras_n, link.cas_n, link.we_n} <= 4'h3;
          CMD_WRITE: {link.cs_n, link.ras_n, link.cas_n, link.we_n} <= 4'h4;
          CMD_READ: {link.cs_n, link.ras_n, link.cas_n, link.we_n} <= 4'h5;
          default: {link.cs_n, link.ras_n, link.cas_n, link.we_n} <= 4'h6;
        endcase
      end else begin
        {link.cs_n, link.ras_n, link.cas_n, link.we_n} <= 4'hF;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Timing guards
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pulse_cnt <= '0;
      mode_cnt <= '0;
      srx_cnt <= '0;
      wr_cnt <= '0;
      burst_cnt <= '0;
      in_sr <= 1'b0;
    end else begin
      // Hold level for the minimum pulse; load one short since the changing edge counts
      if (go_low || go_high) begin
        pulse_cnt <= `TIMER_W'(`MIN_CLOCK_ENABLE_PULSE - 1);
      end else if (pulse_cnt != '0) begin
        pulse_cnt <= pulse_cnt - `TIMER_W'h001;
      end
      if (send && cmd_i == CMD_MODE_SET) begin
        mode_cnt <= `TIMER_W'(`MODE_REG_UPDATE_INTERVAL);
      end else if (mode_cnt != '0) begin
        mode_cnt <= mode_cnt - `TIMER_W'h001;
      end
      if (send && (cmd_i == CMD_READ || cmd_i == CMD_WRITE)) begin
        burst_cnt <= `TIMER_W'h004;
      end else if (burst_cnt != '0) begin
        burst_cnt <= burst_cnt - `TIMER_W'h001;
      end
      if (go_low) begin
        in_sr <= sr_req_i;
      end else if (go_high) begin
        in_sr <= 1'b0;
      end
      if (go_high && in_sr) begin
        // Dll interval covers both the read wait and exit interval
        srx_cnt <= `TIMER_W'(`SELF_REFRESH_EXIT_DLL_INTERVAL);
        wr_cnt <= `TIMER_W'(`FIRST_WRITE_AFTER_SR);
      end else begin
        if (srx_cnt != '0) srx_cnt <= srx_cnt - `TIMER_W'h001;
        if (wr_cnt != '0) wr_cnt <= wr_cnt - `TIMER_W'h001;
      end
    end
  end

  // Asleep flag from go_low and go_high, in step with the pin register
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      asleep_o <= 1'b0;
    end else begin
      asleep_o <= go_low ? 1'b1 : (go_high ? 1'b0 : asleep_o);
    end
  end
endmodule

// ---- testbench/cke_link_props.sv ----
// Checker for the clock-enable link and the device power state.
// Assumes the bench hands in the link wires and the device state.
`timescale 1ns/1ps
module cke_link_props (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  // Link wires
  input wire logic cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic a10,
  input wire logic [2:0] bank,
  // Device side
  input wire cke_power_pkg::pstate_t state_o
);
  import cke_power_pkg::*;
  logic quiet; // Deselect or no-operation on the pins
  logic refr; // Refresh on the pins
  logic col; // Read or write on the pins
  logic [9:0] srx_cnt; // Guard left after self-refresh exit
  logic [3:0] mode_cnt; // Guard left after a mode-register set
  logic [7:0] open_map; // Banks the pins have opened
  logic act; // Activate on the pins
  logic pre; // Precharge on the pins
  assign act = ~cs_n & ~ras_n & cas_n & we_n;
  assign pre = ~cs_n & ~ras_n & cas_n & ~we_n;
  assign quiet = cs_n | (ras_n & cas_n & we_n);
  assign refr = ~cs_n & ~ras_n & ~cas_n & we_n;
  assign col = ~cs_n & ras_n & ~cas_n;
  ////////////////////////////////////////
  // Guards load one short, since the loading edge already counts
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      srx_cnt <= 10'h000;
    end else if ($rose(cke) && state_o == ST_SELF_REF) begin
      srx_cnt <= 10'h1FF;
    end else if (srx_cnt != 10'h000) begin
      srx_cnt <= srx_cnt - 10'h001;
    end
  end
  // Open-bank map from the pins; commands count only with enable high twice
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      open_map <= 8'h00;
    end else if (cke && $past(cke)) begin
      if (act) begin
        open_map[bank] <= 1'b1;
      end else if (pre && a10) begin
        open_map <= 8'h00;
      end else if (pre || (col && a10)) begin
        open_map[bank] <= 1'b0;
      end
    end
  end
  // Mode-register set restarts its own guard
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      mode_cnt <= 4'h0;
    end else if (!cs_n && !ras_n && !cas_n && !we_n) begin
      mode_cnt <= 4'hB;
    end else if (mode_cnt != 4'h0) begin
      mode_cnt <= mode_cnt - 4'h1;
    end
  end
  ////////////////////////////////////////
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!arst_n_i);
  chk_fall_quiet: assert property (
    $fell(cke) |-> quiet || refr) else $error("bad command at enable fall");
  chk_rise_quiet: assert property (
    $rose(cke) |-> quiet) else $error("bad command at enable rise");
  chk_pulse_hold: assert property (
    $changed(cke) |=> $stable(cke)[*3]) else $error("enable pulse too short");
  chk_sleep_keep: assert property (
    !cke && !$past(cke) && state_o inside {ST_ACT_PD, ST_PRE_PD, ST_SELF_REF}
    |=> $stable(state_o)) else $error("sleep state left with enable low");
  chk_sr_entry: assert property (
    $fell(cke) && refr |-> state_o == ST_IDLE ##1 state_o == ST_SELF_REF)
    else $error("self refresh entry wrong");
  chk_act_pd: assert property (
    $fell(cke) && quiet && open_map != 8'h00 &&
    state_o inside {ST_IDLE, ST_ACTIVE} |=> state_o == ST_ACT_PD)
    else $error("active power down not entered");
  chk_pre_pd: assert property (
    $fell(cke) && quiet && open_map == 8'h00 &&
    state_o inside {ST_IDLE, ST_ACTIVE} |=> state_o == ST_PRE_PD)
    else $error("precharge power down not entered");
  chk_idle_cke: assert property (
    state_o == ST_IDLE |-> $past(cke)) else $error("idle with enable low");
  chk_srx_quiet: assert property (
    srx_cnt > 10'h1F0 |-> quiet) else $error("command inside exit interval");
  chk_col_gap: assert property (
    col |-> srx_cnt == 10'h000) else $error("access too soon after exit");
  chk_mode_gap: assert property (
    $fell(cke) |-> mode_cnt == 4'h0) else $error("enable low too soon");
endmodule

// ---- testbench/testbench.sv ----
// Bench joining controller and device over the link.
// Assumes design files and checker are compiled first.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin \
  fail_count++; $display("[ERR] %s exp %h got %h", nm, e, g); end end
module testbench;
  import cke_power_pkg::*;
  logic clk_sys_i = 1'b0; // 50 MHz clock
  logic arst_n_i = 1'b0; // Reset, active low
  cmd_t cmd_i = CMD_DESELECT; // User command
  logic [2:0] bank_i = 3'h0;
  logic a10_i = 1'b0;
  logic odt_i = 1'b0;
  logic pd_req_i = 1'b0;
  logic sr_req_i = 1'b0;
  logic wake_req_i = 1'b0;
  logic accept_o;
  logic asleep_o;
  logic refresh_busy_o;
  logic odt_active_o;
  logic illegal_o;
  logic exit_busy_o;
  pstate_t state_o;
  logic [4:0] last_state = 5'h01; // State seen by the monitor
  logic [4:0] exp_s;
  logic [4:0] exp_q[$]; // Expected state changes, oldest first
  logic [2:0] b;
  int fail_count = 0;
  int total_checks = 0;
  int cycles = 0;
  int n;
  cke_link_if link ();
  cke_power_ctrl u_cke_power_ctrl (.clk_sys_i(clk_sys_i),
    .arst_n_i(arst_n_i), .link(link), .cmd_i(cmd_i), .bank_i(bank_i),
    .a10_i(a10_i), .odt_i(odt_i), .pd_req_i(pd_req_i), .sr_req_i(sr_req_i),
    .wake_req_i(wake_req_i), .accept_o(accept_o), .asleep_o(asleep_o));
  cke_power_device u_cke_power_device (.clk_sys_i(clk_sys_i),
    .arst_n_i(arst_n_i), .link(link), .state_o(state_o),
    .refresh_busy_o(refresh_busy_o), .odt_active_o(odt_active_o),
    .illegal_o(illegal_o), .exit_busy_o(exit_busy_o));
  cke_link_props u_cke_link_props (.clk_sys_i(clk_sys_i),
    .arst_n_i(arst_n_i), .cke(link.cke), .cs_n(link.cs_n),
    .ras_n(link.ras_n), .cas_n(link.cas_n), .we_n(link.we_n),
    .a10(link.a10), .bank(link.bank), .state_o(state_o));
  ////////////////////////////////////////
  initial begin
    forever #10 clk_sys_i = ~clk_sys_i;
  end
  // Verdict; also reached from the hang limit
  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // Hold a command until the controller takes it
  task automatic send(input cmd_t c, input logic [2:0] bk, input logic a);
    @(negedge clk_sys_i);
    cmd_i = c;
    bank_i = bk;
    a10_i = a;
    n = 0;
    do begin
      @(negedge clk_sys_i);
      n++;
    end while (accept_o !== 1'b1 && n < 2000);
    // A command never taken counts as a mismatch
    `CHK("accept", 1'b1, accept_o)
    cmd_i = CMD_DESELECT;
  endtask
  // Power request: 0 power down, 1 self refresh, 2 wake
  task automatic power(input int k);
    @(negedge clk_sys_i);
    pd_req_i = (k == 0);
    sr_req_i = (k == 1);
    wake_req_i = (k == 2);
    n = 0;
    do begin
      @(negedge clk_sys_i);
      n++;
    end while (asleep_o !== (k != 2) && n < 200);
    // A request that never lands counts as a mismatch
    `CHK("asleep", 1'(k != 2), asleep_o)
    pd_req_i = 1'b0;
    sr_req_i = 1'b0;
    wake_req_i = 1'b0;
    // Let the device state follow before the next request
    repeat (6) @(negedge clk_sys_i);
  endtask
  ////////////////////////////////////////
  // Monitor at the falling edge, where outputs have settled
  always @(negedge clk_sys_i) begin
    if (arst_n_i && state_o !== last_state) begin
      exp_s = (exp_q.size() != 0) ? exp_q.pop_front() : 5'h00;
      `CHK("state", exp_s, state_o)
      last_state = state_o;
    end
    if (illegal_o !== 1'b0) `CHK("illegal", 1'b0, illegal_o)
  end
  // Hang limit, far above the under one thousand cycles needed
  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 8000) begin
      fail_count++;
      $display("[ERR] run exp done got hang");
      results();
    end
  end
  ////////////////////////////////////////
  initial begin
    void'($urandom(32'h91372616));
    repeat (20) @(negedge clk_sys_i);
    arst_n_i = 1'b1;
    exp_q.push_back(ST_PRE_PD);
    power(0);
    exp_q.push_back(ST_ACTIVE);
    exp_q.push_back(ST_IDLE);
    power(2);
    $display("test 1 done");
    // Random bank, access, then power down during the burst
    for (int i = 0; i < 3; i++) begin
      b = 3'($urandom);
      odt_i = 1'($urandom);
      exp_q.push_back(ST_ACTIVE);
      send(CMD_ACTIVATE, b, 1'b0);
      exp_q.push_back(ST_ACT_PD);
      power(0);
      exp_q.push_back(ST_ACTIVE);
      power(2);
      send(($urandom % 2) ? CMD_READ : CMD_WRITE, b, 1'b0);
      exp_q.push_back(ST_ACT_PD);
      power(0);
      exp_q.push_back(ST_ACTIVE);
      power(2);
      exp_q.push_back(ST_IDLE);
      send(CMD_PRECHARGE, b, 1'b1);
    end
    $display("test 2 done");
    // Sleep right after a mode set must wait out its guard
    send(CMD_MODE_SET, 3'h0, 1'b0);
    exp_q.push_back(ST_PRE_PD);
    power(0);
    exp_q.push_back(ST_ACTIVE);
    exp_q.push_back(ST_IDLE);
    power(2);
    $display("test 3 done");
    // Self refresh with termination asked for, then a long exit guard
    odt_i = 1'b1;
    exp_q.push_back(ST_SELF_REF);
    power(1);
    repeat (40) @(negedge clk_sys_i);
    `CHK("refresh_busy", 1'b1, refresh_busy_o)
    `CHK("odt_active", 1'b0, odt_active_o)
    exp_q.push_back(ST_ACTIVE);
    exp_q.push_back(ST_IDLE);
    power(2);
    `CHK("exit_busy", 1'b1, exit_busy_o)
    `CHK("refresh_busy", 1'b0, refresh_busy_o)
    exp_q.push_back(ST_ACTIVE);
    send(CMD_ACTIVATE, 3'($urandom), 1'b0);
    `CHK("exit_wait", 1'b1, n >= 480)
    `CHK("exit_busy", 1'b0, exit_busy_o)
    `CHK("odt_active", 1'b1, odt_active_o)
    send(CMD_WRITE, 3'h0, 1'b0);
    exp_q.push_back(ST_IDLE);
    send(CMD_PRECHARGE, 3'h0, 1'b1);
    $display("test 4 done");
    repeat (10) @(negedge clk_sys_i);
    `CHK("queue", 0, exp_q.size())
    results();
  end
endmodule
